// >>> rtl/adc_link_cfg.svh
// Purpose: Shared constants for the self-clocking converter serial link
// Assumes: aclk at 10 MHz; serial words of sixteen bits
// Notes:   Counts are derived from times by the expressions below
//
// Operation
// - Free mode: serial clock follows master clock
// - Gated mode: master clock gated by frame
// - Select1 high: select2 low gated, high free
// - Start falling edge begins conversion, raises busy
// - Start rising edge lowers sync shortly after
// - Sixteen clocks per frame, then sync high, busy low
// - Current result out; input word for next
// - Next start at least 400 ns after busy
// - Free mode: sync falls after serial clock rise; here sync falls on the same aclk edge as the clock rise
// - First bit at sync fall, rest on rises
// - Input bit captured on each active rise
// - Polarity swaps sample and launch edges
// - Sync rises after sixteenth edge, no extra bit
// - Control start bit starts conversion and frame
// - After software conversion, frames need pin toggle
// - Controller avoids software starts without pin control
// - Transfers only while sync is low
// - Master clock runs for power-on calibration
// - Two-wire mode only via control bit, alternating
// - All-zero input word changes no register
// - Silent controller may hold input low
// - Tied clock: sync low exactly sixteen cycles
`ifndef ADC_LINK_CFG_SVH
`define ADC_LINK_CFG_SVH

`define CLK_PERIOD_NS      100
`define FRAME_BITS         5'h10
`define LAST_BIT           5'h0f
`define CAL_TIME_US        32000
`define CAL_CLK_MHZ        4
`define CAL_EDGES          (`CAL_TIME_US * `CAL_CLK_MHZ)
`define ACQ_TIME_NS        400
`define ACQ_CYCLES         ((`ACQ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define START_LOW_CYCLES   4

`define CTRL_SOFT_START    0
`define CTRL_TWO_WIRE      1

`define REG_CMD            8'h00
`define REG_TX             8'h04
`define REG_RX             8'h08
`define REG_STATUS         8'h0c
`define CMD_START          0
`define STAT_BUSY          0
`define STAT_RX_VALID      1
`define STAT_PENDING       2

`endif

// >>> rtl/adc_link_pkg.sv
// Purpose: Types shared by both ends of the serial link
// Assumes: Constants come from adc_link_cfg.svh
// Notes:   Each end keeps all of its state in one packed struct
package adc_link_pkg;

  typedef logic [15:0] word_t;
  typedef logic [11:0] sample_t;

  typedef enum logic [1:0] {MODE_EXT, MODE_GATED, MODE_FREE} link_mode_e;

  typedef enum logic [2:0] {ST_CAL, ST_IDLE, ST_CONV, ST_DELAY, ST_FRAME, ST_END} dev_state_e;

  typedef struct packed {
    dev_state_e  state;
    logic        mclk_m, mclk_s, mclk_q;
    logic        cs_m, cs_s, cs_q;
    logic        din_m, din_s;
    logic [19:0] cal_cnt;
    logic [4:0]  bit_cnt;
    word_t       shreg, rxreg, ctrl;
    logic        sclk, sync_n, dout, busy;
    logic        soft_pend, soft_run, locked, read_phase;
  } dev_reg_s;

  typedef struct packed {
    logic        aw_hold, w_hold, bvalid, rvalid;
    logic [7:0]  aw_addr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    word_t       tx, rx, sh_in, sh_out;
    logic        rx_valid, start_req, cs_n, din;
    logic [3:0]  cs_cnt, gap_cnt;
    logic [4:0]  bits;
    logic        sclk_m, sclk_s, sclk_q;
    logic        fs_m, fs_s, fs_q;
    logic        dout_m, dout_s, dout_q;
    logic        busy_m, busy_s;
  } ctl_reg_s;

endpackage

// >>> rtl/adc_link_if.sv
// Purpose: Pins between the converter port and the receiving controller
// Assumes: master_clock_in is driven by the surroundings
// Notes:   No two-way pins; dout and din are one-way
`timescale 1ns/1ps
interface adc_link_if;
  logic master_clock_in;
  logic conversion_start_n;
  logic sclk;
  logic frame_sync_n;
  logic dout;
  logic din;
  logic busy;

  modport device (
    input  master_clock_in,
    input  conversion_start_n,
    input  din,
    output sclk,
    output frame_sync_n,
    output dout,
    output busy
  );

  modport controller (
    input  sclk,
    input  frame_sync_n,
    input  dout,
    input  busy,
    output conversion_start_n,
    output din
  );
endinterface

// >>> rtl/adc_serial_master.sv
// Purpose: Converter serial port in its self-clocking modes (frame master)
// Assumes: Link pins are asynchronous and pass two flip-flops first
// Notes:   The conversion itself is modelled by sampling sample_value
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "adc_link_cfg.svh"

module adc_serial_master #(
  parameter int unsigned CAL_EDGES = `CAL_EDGES
) (
  input  wire logic                 aclk,          // System clock
  input  wire logic                 aresetn,       // Synchronous reset, low
  input  wire logic                 ce,            // Clock enable
  input  wire logic                 mode_select_1, // Mode strap 1
  input  wire logic                 mode_select_2, // Mode strap 2
  input  wire logic                 polarity,      // Swap active clock edge
  input  adc_link_pkg::sample_t     sample_value,  // Value to convert
  output logic                      calibrated,    // Power-on calibration done
  output logic                      locked_out,    // Frames need a pin start
  output adc_link_pkg::word_t       control_word,  // Current control register
  adc_link_if.device                link           // Serial pins
);
  import adc_link_pkg::*;

  localparam dev_reg_s DEV_RESET = '{
    state:   ST_CAL,
    cs_m:    1'b1,
    cs_s:    1'b1,
    cs_q:    1'b1,
    sync_n:  1'b1,
    default: '0
  };

  dev_reg_s   r;
  dev_reg_s   n;
  link_mode_e mode;
  logic       mclk_rise;
  logic       mclk_fall;
  logic       cs_fall;
  logic       cs_rise;
  logic       act_edge;
  logic       in_frame;
  logic       two_wire;
  logic       dout_on;
  logic       din_on;

  function automatic link_mode_e decode_mode(input logic m1, input logic m2);
    if (m1 && m2) begin
      return MODE_FREE;
    end else if (m1) begin
      return MODE_GATED;
    end else begin
      return MODE_EXT;
    end
  endfunction

  function automatic logic rose(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  function automatic word_t result_word(input sample_t s);
    return {4'h0, s};
  endfunction

  assign mode      = decode_mode(mode_select_1, mode_select_2);
  assign mclk_rise = rose(r.mclk_s, r.mclk_q);
  assign mclk_fall = rose(r.mclk_q, r.mclk_s);
  assign cs_fall   = rose(r.cs_q, r.cs_s);
  assign cs_rise   = rose(r.cs_s, r.cs_q);
  assign act_edge  = polarity ? mclk_fall : mclk_rise;
  assign in_frame  = (r.state == ST_FRAME) || (r.state == ST_END);
  assign two_wire  = r.ctrl[`CTRL_TWO_WIRE];
  // Two-wire frames alternate: write frames capture, read frames drive
  assign dout_on   = !two_wire || r.read_phase;
  assign din_on    = !two_wire || !r.read_phase;

  always_comb begin
    n = r;
    n.mclk_m = link.master_clock_in;
    n.mclk_s = r.mclk_m;
    n.mclk_q = r.mclk_s;
    n.cs_m   = link.conversion_start_n;
    n.cs_s   = r.cs_m;
    n.cs_q   = r.cs_s;
    n.din_m  = link.din;
    n.din_s  = r.din_m;

    // Clock output regenerated from the sampled master clock
    if (mode == MODE_FREE) begin
      n.sclk = r.mclk_s;
    end else if (mode == MODE_GATED) begin
      n.sclk = r.mclk_s & in_frame;
    end else begin
      n.sclk = 1'b0;
    end

    // A pin start reopens the link after a software conversion, unless it falls in the ST_END cycle that locks it
    if (cs_fall) begin
      n.locked = 1'b0;
    end

    case (r.state)
      ST_CAL: begin
        // Calibration only advances while the master clock runs
        if (mclk_rise) begin
          if (r.cal_cnt == 20'(CAL_EDGES - 1)) begin
            n.state = ST_IDLE;
          end else begin
            n.cal_cnt = r.cal_cnt + 20'h1;
          end
        end
      end
      ST_IDLE: begin
        if (mode != MODE_EXT) begin
          if (cs_fall) begin
            n.busy     = 1'b1;
            n.soft_run = 1'b0;
            n.state    = ST_CONV;
          end else if (r.soft_pend && !r.locked) begin
            n.busy      = 1'b1;
            n.soft_pend = 1'b0;
            n.soft_run  = 1'b1;
            n.state     = ST_DELAY;
          end
        end
      end
      ST_CONV: begin
        if (cs_rise) begin
          n.state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        // Free mode waits for a clock rise; gated mode for a fall so
        // the gated clock never shows a runt pulse at frame start
        if ((mode == MODE_FREE) ? mclk_rise : mclk_fall) begin
          n.sync_n  = 1'b0;
          n.bit_cnt = 5'h00;
          n.shreg   = result_word(sample_value);
          n.dout    = dout_on & sample_value[11] & 1'b0;
          n.rxreg   = '0;
          n.state   = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (act_edge) begin
          if (din_on) begin
            n.rxreg = {r.rxreg[14:0], r.din_s};
          end
          n.bit_cnt = r.bit_cnt + 5'h01;
          if (r.bit_cnt == `LAST_BIT) begin
            // Sync rises one cycle later, before the next opposite edge
            n.state = ST_END;
          end else begin
            n.shreg = {r.shreg[14:0], 1'b0};
            n.dout  = dout_on & r.shreg[14];
          end
        end
      end
      ST_END: begin
        n.sync_n = 1'b1;
        n.busy   = 1'b0;
        n.dout   = 1'b0;
        n.state  = ST_IDLE;
        // Word shifted in applies from the following conversion on
        if (din_on && (r.rxreg != '0)) begin
          n.ctrl      = r.rxreg;
          n.soft_pend = r.rxreg[`CTRL_SOFT_START];
        end
        if (r.soft_run) begin
          n.locked = 1'b1;
        end
        if (two_wire) begin
          n.read_phase = ~r.read_phase;
        end
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= DEV_RESET;
    end else if (ce) begin
      r <= n;
    end
  end

  // First data bit is driven straight from the shift register at sync fall
  assign link.sclk         = r.sclk;
  assign link.frame_sync_n = r.sync_n;
  assign link.dout         = (r.state == ST_FRAME) ? (dout_on & r.shreg[15]) : r.dout;
  assign link.busy         = r.busy;
  assign calibrated        = (r.state != ST_CAL);
  assign locked_out        = r.locked;
  assign control_word      = r.ctrl;

endmodule

// >>> rtl/dsp_slave_end.sv
// Purpose: Receiving controller end, ordered by software over AXI4-Lite
// Assumes: Link inputs are asynchronous; two flip-flops before use
// Notes:   Start pulses are held off until acquisition time has passed
`timescale 1ns/1ps
`include "adc_link_cfg.svh"

module dsp_slave_end (
  input  wire logic        aclk,          // System clock
  input  wire logic        aresetn,       // Synchronous reset, low
  input  wire logic        ce,            // Clock enable
  input  wire logic        polarity,      // Swap active clock edge
  input  wire logic [7:0]  s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [7:0]  s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read valid
  input  wire logic        s_axi_rready,  // Read ready
  adc_link_if.controller   link           // Serial pins
);
  import adc_link_pkg::*;

  localparam ctl_reg_s CTL_RESET = '{
    cs_n: 1'b1, sclk_m: 1'b0, fs_m: 1'b1, fs_s: 1'b1, fs_q: 1'b1, default: '0
  };

  ctl_reg_s r;
  ctl_reg_s n;
  logic     edge_seen;
  logic     rx_read;

  function automatic logic known_reg(input logic [7:0] a);
    return (a == `REG_CMD) || (a == `REG_TX) || (a == `REG_RX) || (a == `REG_STATUS);
  endfunction

  assign edge_seen = polarity ? (r.sclk_q & ~r.sclk_s) : (r.sclk_s & ~r.sclk_q);
  assign rx_read   = s_axi_arvalid && !r.rvalid && (s_axi_araddr == `REG_RX);

  always_comb begin
    n = r;
    n.sclk_m = link.sclk;
    n.sclk_s = r.sclk_m;
    n.sclk_q = r.sclk_s;
    n.fs_m   = link.frame_sync_n;
    n.fs_s   = r.fs_m;
    n.fs_q   = r.fs_s;
    n.dout_m = link.dout;
    n.dout_s = r.dout_m;
    n.dout_q = r.dout_s;
    n.busy_m = link.busy;
    n.busy_s = r.busy_m;

    // Write channels, taken in either order
    if (s_axi_awvalid && !r.aw_hold && !r.bvalid) begin
      n.aw_hold = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_hold && !r.bvalid) begin
      n.w_hold = 1'b1;
      n.wdata  = s_axi_wdata;
      n.wstrb  = s_axi_wstrb;
    end
    if (r.aw_hold && r.w_hold) begin
      n.aw_hold = 1'b0;
      n.w_hold  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = known_reg(r.aw_addr) ? 2'b00 : 2'b10;
      if ((r.aw_addr == `REG_CMD) && r.wstrb[0] && r.wdata[`CMD_START]) begin
        n.start_req = 1'b1;
      end
      if (r.aw_addr == `REG_TX) begin
        if (r.wstrb[0]) n.tx[7:0] = r.wdata[7:0];
        if (r.wstrb[1]) n.tx[15:8] = r.wdata[15:8];
      end
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // Read channel; reading the received word clears its flag
    if (s_axi_arvalid && !r.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp  = known_reg(s_axi_araddr) ? 2'b00 : 2'b10;
      if (s_axi_araddr == `REG_STATUS) begin
        n.rdata = {29'h0, r.start_req, r.rx_valid, r.busy_s};
      end else if (s_axi_araddr == `REG_RX) begin
        n.rdata = {16'h0, r.rx};
      end else if (s_axi_araddr == `REG_TX) begin
        n.rdata = {16'h0, r.tx};
      end else begin
        n.rdata = 32'h0;
      end
    end
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (rx_read) begin
      n.rx_valid = 1'b0;
    end

    // Acquisition gap after busy falls before the next start pulse
    if (r.busy_s) begin
      n.gap_cnt = 4'h0;
    end else if (r.gap_cnt != 4'(`ACQ_CYCLES)) begin
      n.gap_cnt = r.gap_cnt + 4'h1;
    end
    if (!r.cs_n) begin
      if (r.cs_cnt == 4'(`START_LOW_CYCLES - 1)) begin
        n.cs_n      = 1'b1;
        n.start_req = 1'b0;
      end else begin
        n.cs_cnt = r.cs_cnt + 4'h1;
      end
    end else if (r.start_req && !r.busy_s && (r.gap_cnt == 4'(`ACQ_CYCLES))) begin
      n.cs_n   = 1'b0;
      n.cs_cnt = 4'h0;
    end

    // Outside a frame the first outgoing bit is already waiting
    if (r.fs_s) begin
      n.bits   = 5'h00;
      n.sh_out = r.tx;
      n.din    = r.tx[15];
    end else if (edge_seen && !r.fs_q && (r.bits != `FRAME_BITS)) begin
      // Free clock rises with the sync fall; that edge carries no bit
      // Old dout sample is the bit that stood before this edge
      n.sh_in  = {r.sh_in[14:0], r.dout_q};
      n.bits   = r.bits + 5'h01;
      n.sh_out = {r.sh_out[14:0], 1'b0};
      n.din    = r.sh_out[14];
      if (r.bits == `LAST_BIT) begin
        n.rx       = {r.sh_in[14:0], r.dout_q};
        n.rx_valid = 1'b1; // Set wins over a read in the same cycle
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= CTL_RESET;
    end else if (ce) begin
      r <= n;
    end
  end

  assign s_axi_awready           = !r.aw_hold && !r.bvalid;
  assign s_axi_wready            = !r.w_hold && !r.bvalid;
  assign s_axi_bvalid            = r.bvalid;
  assign s_axi_bresp             = r.bresp;
  assign s_axi_arready           = !r.rvalid;
  assign s_axi_rvalid            = r.rvalid;
  assign s_axi_rdata             = r.rdata;
  assign s_axi_rresp             = r.rresp;
  assign link.conversion_start_n = r.cs_n;
  assign link.din                = r.din;

endmodule

// >>> verification/adc_link_asserts.sv
// Purpose: Concurrent checks on the serial link between both ends
// Assumes: Link pins are sampled on aclk; straps change only between frames
// Notes:   Straps and polarity are watched too, to know mode and active edge
`timescale 1ns/1ps

module adc_link_asserts (
  input wire logic aclk,               // System clock
  input wire logic aresetn,            // Synchronous reset, low
  input wire logic mode_select_1,      // Mode strap 1
  input wire logic mode_select_2,      // Mode strap 2
  input wire logic polarity,           // Active edge select
  input wire logic conversion_start_n, // Start pin
  input wire logic sclk,               // Serial clock
  input wire logic frame_sync_n,       // Frame sync
  input wire logic dout,               // Device data
  input wire logic busy                // Conversion busy
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic       sclk_q;
  logic       sync_q;
  logic       act_edge;
  logic       free_mode;
  logic       gated_mode;
  logic [5:0] edge_cnt;
  logic [3:0] still_cnt;

  assign free_mode  = mode_select_1 & mode_select_2;
  assign gated_mode = mode_select_1 & ~mode_select_2;
  assign act_edge   = polarity ? (sclk_q & ~sclk) : (~sclk_q & sclk);

  // Edge at the sync fall itself is not counted; one at the sync rise is
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_q    <= 1'b0;
      sync_q    <= 1'b1;
      edge_cnt  <= 6'h00;
      still_cnt <= 4'h0;
    end else begin
      sclk_q <= sclk;
      sync_q <= frame_sync_n;
      if (frame_sync_n && sync_q)
        edge_cnt <= 6'h00;
      else if (act_edge && !sync_q)
        edge_cnt <= edge_cnt + 6'h01;
      if (!free_mode || sclk != sclk_q)
        still_cnt <= 4'h0;
      else if (still_cnt != 4'hf)
        still_cnt <= still_cnt + 4'h1;
    end
  end

  sequence seq_start_low;
    !conversion_start_n [*4] ##1 conversion_start_n;
  endsequence

  sequence seq_frame_open;
    ##[1:16] !frame_sync_n;
  endsequence

  AST_START_PULSE: assert property ($fell(conversion_start_n) |-> seq_start_low)
    else $error("start pulse not four cycles low");
  AST_BUSY_RISE: assert property ($fell(conversion_start_n) && !busy && mode_select_1
    |-> ##[1:4] busy) else $error("busy did not follow start");
  AST_SYNC_FALL: assert property ($rose(conversion_start_n) && busy && mode_select_1
    |-> seq_frame_open) else $error("frame did not open after start");
  AST_SIXTEEN: assert property ($rose(frame_sync_n) |=> edge_cnt == 6'h10)
    else $error("frame did not hold sixteen active edges");
  AST_NO_EXTRA: assert property (!frame_sync_n |-> edge_cnt <= 6'h10)
    else $error("more than sixteen edges in a frame");
  AST_BUSY_END: assert property ($rose(frame_sync_n) |-> ##[0:1] !busy)
    else $error("busy stayed high after frame");
  AST_GATED_QUIET: assert property (gated_mode && frame_sync_n && sync_q |-> !$rose(sclk))
    else $error("serial clock rose outside frame");
  AST_FREE_RUN: assert property (free_mode |-> still_cnt < 4'ha)
    else $error("free serial clock stopped");
  AST_DOUT_LAUNCH: assert property (!frame_sync_n && !sync_q && $changed(dout) |-> act_edge)
    else $error("data changed off the launch edge");
  AST_START_GAP: assert property ($fell(busy) |-> conversion_start_n [*4])
    else $error("start too soon after busy fell");
endmodule

// >>> verification/test_self_clocking_adc_serial_master.sv
// Purpose: Self-checking bench joining both ends of the serial link
// Assumes: Calibration shortened to four master clock rises
// Notes:   Software drives the controller end over AXI4-Lite
`timescale 1ns/1ps
`include "adc_link_cfg.svh"

module test_self_clocking_adc_serial_master;
  import adc_link_pkg::*;

  typedef struct packed {logic ms2; logic pol; word_t tx; sample_t smp;} case_s;

  logic        aclk, aresetn, mode_select_1, mode_select_2, polarity;
  sample_t     sample_value;
  logic        calibrated, locked_out;
  word_t       control_word, exp_ctrl;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, sync_q;
  int          n_mismatch, num_checks, cycles, falls, f0, c0;
  case_s       cases [4] = '{'{1'b1, 1'b0, 16'h5a50, 12'habc}, '{1'b1, 1'b0, 16'h0000, 12'h123},
                             '{1'b0, 1'b1, 16'ha5a4, 12'h5c3}, '{1'b1, 1'b1, 16'h3c3c, 12'hfff}};

  adc_link_if link_if();

  adc_serial_master #(.CAL_EDGES(4)) adc_serial_master_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .mode_select_1(mode_select_1),
    .mode_select_2(mode_select_2), .polarity(polarity), .sample_value(sample_value),
    .calibrated(calibrated), .locked_out(locked_out), .control_word(control_word),
    .link(link_if));

  dsp_slave_end dsp_slave_end_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .polarity(polarity),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link(link_if));

  adc_link_asserts adc_link_asserts_inst (
    .aclk(aclk), .aresetn(aresetn), .mode_select_1(mode_select_1),
    .mode_select_2(mode_select_2), .polarity(polarity),
    .conversion_start_n(link_if.conversion_start_n), .sclk(link_if.sclk),
    .frame_sync_n(link_if.frame_sync_n), .dout(link_if.dout), .busy(link_if.busy));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Offset keeps the master clock out of phase with aclk
  initial begin
    link_if.master_clock_in = 1'b0;
    #137;
    forever #400 link_if.master_clock_in = ~link_if.master_clock_in;
  end

  task automatic stop_test;
    $display("Checks: %0d, mismatches: %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Frame starts are counted here; a hang ends the run
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    sync_q <= link_if.frame_sync_n;
    if (sync_q === 1'b1 && link_if.frame_sync_n === 1'b0)
      falls <= falls + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("MISMATCH at %0t: run did not finish", $time);
      stop_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s, got %h, expected %h", $time, what, got, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Polls status until a word has arrived, then fetches it
  task automatic run_frame(input word_t tx);
    axi_write(`REG_TX, {16'h0000, tx}, r);
    axi_write(`REG_CMD, 32'h1, r);
    do axi_read(`REG_STATUS, d, r); while (d[`STAT_RX_VALID] !== 1'b1);
    axi_read(`REG_RX, d, r);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, polarity} = '0;
    {awaddr, araddr, wdata, sample_value} = '0;
    {n_mismatch, num_checks, cycles, falls} = '0;
    {mode_select_1, mode_select_2, sync_q} = 3'b111;
    exp_ctrl = 16'h0000;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({28'h0, link_if.sclk, link_if.frame_sync_n, link_if.busy,
           link_if.conversion_start_n}, 32'h5, "idle pins");
    check({31'h0, calibrated}, 32'h0, "calibrated at reset");
    c0 = cycles;
    while (calibrated !== 1'b1) @(posedge aclk);
    check(32'((cycles - c0) inside {[24:50]}), 32'h1, "calibration time");
    $display("Test reset and calibration done");
    axi_read(`REG_STATUS, d, r);
    check({31'h0, d[`STAT_BUSY]}, 32'h0, "status busy");
    axi_write(8'h20, 32'h1, r);
    check({30'h0, r}, 32'h2, "write refusal");
    axi_read(8'h20, d, r);
    check({d[31:2], r}, 32'h2, "read refusal");
    $display("Test registers done");
    foreach (cases[i]) begin
      @(posedge aclk);
      mode_select_2 <= cases[i].ms2;
      polarity      <= cases[i].pol;
      sample_value  <= cases[i].smp;
      if (cases[i].tx !== 16'h0000) exp_ctrl = cases[i].tx;
      run_frame(cases[i].tx);
      check(d, {20'h0, cases[i].smp}, "result word");
      check({16'h0, control_word}, {16'h0, exp_ctrl}, "control word");
      check({31'h0, locked_out}, 32'h0, "lock after pin frame");
    end
    $display("Test frames done");
    @(posedge aclk);
    polarity <= 1'b0;
    f0 = falls;
    axi_write(`REG_TX, 32'h1, r);
    axi_write(`REG_CMD, 32'h1, r);
    while (locked_out !== 1'b1) @(posedge aclk);
    check(32'(falls - f0), 32'd2, "pin frame then software frame");
    f0 = falls;
    repeat (300) @(posedge aclk);
    check(32'(falls - f0), 32'd0, "frame while locked");
    axi_read(`REG_RX, d, r);
    run_frame(16'h0040);
    check({31'h0, locked_out}, 32'h0, "lock cleared by pin");
    check({16'h0, control_word}, 32'h40, "control word after lock");
    $display("Test software start done");
    // Two-wire: first frame after setting the bit writes, the next one reads
    run_frame(16'h0002);
    check(d, 32'hfff, "result before two-wire");
    run_frame(16'h0002);
    check(d, 32'h0, "write frame result");
    run_frame(16'h0100);
    check(d, 32'hfff, "read frame result");
    check({16'h0, control_word}, 32'h2, "read frame ignores input");
    $display("Test two-wire done");
    @(posedge aclk);
    mode_select_1 <= 1'b0;
    f0 = falls;
    axi_write(`REG_CMD, 32'h1, r);
    repeat (300) @(posedge aclk);
    check(32'(falls - f0), 32'd0, "frame in external clock mode");
    $display("Test mode select done");
    stop_test();
  end
endmodule
